// File: ocfr_pkg.sv
// Shared constants, types and helpers for the over-current fault response block.
`default_nettype none
package ocfr_pkg;

    typedef logic [15:0] ocfr_word_t;
    typedef logic [7:0] ocfr_byte_t;
    typedef logic [1:0] ocfr_resp_t;
    typedef logic [2:0] ocfr_field3_t;

    // Command codes of the two fault-limit registers on the management port.
    localparam ocfr_byte_t OCFR_CMD_THRESH = 8'h46;
    localparam ocfr_byte_t OCFR_CMD_RESP = 8'h47;

    // Response setting field positions.
    localparam int OCFR_RESP_MSB = 7;
    localparam int OCFR_RESP_LSB = 6;
    localparam int OCFR_RETRY_MSB = 5;
    localparam int OCFR_RETRY_LSB = 3;
    localparam int OCFR_DELAY_MSB = 2;
    localparam int OCFR_DELAY_LSB = 0;

    // Linear format layout: signed exponent above a signed mantissa.
    localparam int OCFR_EXP_MSB = 15;
    localparam int OCFR_EXP_LSB = 11;
    localparam int OCFR_MANT_MSB = 10;
    localparam logic [4:0] OCFR_EXP_BIAS = 5'h10;

    // Response codes.
    localparam ocfr_resp_t OCFR_RESP_BRICK = 2'h0;
    localparam ocfr_resp_t OCFR_RESP_FLOOR = 2'h1;
    localparam ocfr_resp_t OCFR_RESP_DELAY = 2'h2;
    localparam ocfr_resp_t OCFR_RESP_RESUME = 2'h3;

    // Retry field codes with special meaning.
    localparam ocfr_field3_t OCFR_RETRY_NONE = 3'h0;
    localparam ocfr_field3_t OCFR_RETRY_FOREVER = 3'h7;

    // Reset values of the two registers.
    localparam ocfr_word_t OCFR_THRESH_RST = 16'h07FF;
    localparam ocfr_byte_t OCFR_RESP_RST = 8'h00;

    typedef enum logic [2:0] {
        OCFR_OFF, OCFR_RUN, OCFR_LIMIT, OCFR_SHUT, OCFR_LATCH, OCFR_HOLD
    } ocfr_state_e;

    // Linear value scaled by two to the sixteenth, so every exponent gives an integer.
    function automatic logic signed [42:0] ocfr_lin_to_fix(input ocfr_word_t w);
        logic signed [42:0] m;
        logic [4:0] sh;
        m = 43'(signed'(w[OCFR_MANT_MSB:0]));
        sh = w[OCFR_EXP_MSB:OCFR_EXP_LSB] + OCFR_EXP_BIAS;
        return m <<< sh;
    endfunction

    function automatic ocfr_resp_t ocfr_resp_field(input ocfr_byte_t c);
        return c[OCFR_RESP_MSB:OCFR_RESP_LSB];
    endfunction

    function automatic ocfr_field3_t ocfr_retry_field(input ocfr_byte_t c);
        return c[OCFR_RETRY_MSB:OCFR_RETRY_LSB];
    endfunction

    function automatic ocfr_field3_t ocfr_delay_field(input ocfr_byte_t c);
        return c[OCFR_DELAY_MSB:OCFR_DELAY_LSB];
    endfunction

endpackage
`default_nettype wire

// File: ocfr_if.sv
// Carrier between the fault core, its register store and its delay timer.
`default_nettype none
interface ocfr_if;
    import ocfr_pkg::*;
    logic ce;
    ocfr_word_t thresh;
    ocfr_byte_t resp_cfg;
    logic tmr_start;
    ocfr_field3_t tmr_exp;
    ocfr_word_t tmr_unit;
    logic tmr_done;

    modport regs (input ce, output thresh, output resp_cfg);
    modport tmr (input ce, input tmr_start, input tmr_exp, input tmr_unit, output tmr_done);
    modport core (output ce, input thresh, input resp_cfg, output tmr_start, output tmr_exp,
                  output tmr_unit, input tmr_done);
endinterface
`default_nettype wire

// File: ocfr_regs.sv
// Register store for the current threshold and the response setting.
`default_nettype none
module ocfr_regs (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    ocfr_if.regs bus,
    input wire ocfr_pkg::ocfr_byte_t cmd_code_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire ocfr_pkg::ocfr_word_t cmd_wdata_i,
    output ocfr_pkg::ocfr_word_t cmd_rdata_o,
    output logic cmd_rvalid_o
);
    import ocfr_pkg::*;

    typedef struct packed {
        ocfr_word_t thresh;
        ocfr_byte_t cfg;
        ocfr_word_t rdata;
        logic rvalid;
    } ocfr_regs_s;

    ocfr_regs_s r;
    ocfr_regs_s n;

    // Writes land by command code; reads answer one cycle later, zero for unknown codes.
    always_comb begin
        n = r;
        n.rvalid = cmd_rd_i;
        if (cmd_wr_i) begin
            if (cmd_code_i == OCFR_CMD_THRESH) begin
                n.thresh = cmd_wdata_i;
            end else if (cmd_code_i == OCFR_CMD_RESP) begin
                n.cfg = cmd_wdata_i[OCFR_RESP_MSB:0];
            end
        end
        if (cmd_rd_i) begin
            if (cmd_code_i == OCFR_CMD_THRESH) begin
                n.rdata = r.thresh;
            end else if (cmd_code_i == OCFR_CMD_RESP) begin
                n.rdata = {8'h00, r.cfg};
            end else begin
                n.rdata = '0;
            end
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '{thresh: OCFR_THRESH_RST, cfg: OCFR_RESP_RST, default: '0};
        end else if (bus.ce) begin
            r <= n;
        end
    end

    assign bus.thresh = r.thresh;
    assign bus.resp_cfg = r.cfg;
    assign cmd_rdata_o = r.rdata;
    assign cmd_rvalid_o = r.rvalid;

endmodule // ocfr_regs
`default_nettype wire

// File: ocfr_timer.sv
// Delay timer: counts two-to-the-field time units, each unit a programmed number of cycles.
`default_nettype none
module ocfr_timer (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    ocfr_if.tmr bus
);
    import ocfr_pkg::*;

    typedef struct packed {
        logic busy;
        ocfr_word_t pre;
        ocfr_byte_t units;
        logic done;
    } ocfr_tmr_s;

    ocfr_tmr_s r;
    ocfr_tmr_s n;
    ocfr_word_t unit_last;
    ocfr_byte_t mult_last;

    // A unit of zero cycles is treated as one, so the timer always ends.
    always_comb begin
        unit_last = (bus.tmr_unit == '0) ? '0 : 16'(bus.tmr_unit - 16'h0001);
        mult_last = 8'((8'h01 << bus.tmr_exp) - 8'h01);
        n = r;
        n.done = 1'b0;
        if (bus.tmr_start) begin
            n.busy = 1'b1;
            n.pre = '0;
            n.units = '0;
        end else if (r.busy) begin
            if (r.pre >= unit_last) begin
                n.pre = '0;
                if (r.units >= mult_last) begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end else begin
                    n.units = 8'(r.units + 8'h01);
                end
            end else begin
                n.pre = 16'(r.pre + 16'h0001);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '0;
        end else if (bus.ce) begin
            r <= n;
        end
    end

    assign bus.tmr_done = r.done;

endmodule // ocfr_timer
`default_nettype wire

// File: ocfr_top.sv
// Over-current fault response: limit compare, response state machine and retry control.
// Behaviour
// - Hold 16-bit Linear threshold as current limit.
// - Any response sets the over-current fault flag.
// - Notify host on every detected over-current.
// - Code 00: limit current forever, ignore voltage.
// - Code 01: limit while voltage above floor.
// - Code 01: below floor, shut down, then retry.
// - Code 10: limit for multiplier times time unit.
// - Code 10: still limiting at expiry, then retry.
// - Code 11: output off while over-current persists.
// - Code 11: re-enable output once over-current clears.
// - Retry field sets number of restart attempts.
// - Retry zero means no restart attempt.
// - Retry all ones restarts without limit.
// - No retry: stay off until fault cleared.
// - Delay multiplier is two to the field.
// - Same delay for run-on and restart spacing.
`default_nettype none
module ocfr_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire ocfr_pkg::ocfr_byte_t cmd_code_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire ocfr_pkg::ocfr_word_t cmd_wdata_i,
    output ocfr_pkg::ocfr_word_t cmd_rdata_o,
    output logic cmd_rvalid_o,
    input wire ocfr_pkg::ocfr_word_t iout_meas_i,
    input wire ocfr_pkg::ocfr_word_t vout_meas_i,
    input wire ocfr_pkg::ocfr_word_t overcurrent_voltage_floor_i,
    input wire ocfr_pkg::ocfr_word_t time_unit_cycles_i,
    input wire logic output_on_i,
    input wire logic fault_clear_i,
    output logic output_enable_o,
    output logic current_limit_o,
    output ocfr_pkg::ocfr_word_t limit_level_o,
    output logic oc_fault_flag_o,
    output logic host_alert_o
);
    import ocfr_pkg::*;

    typedef struct packed {
        ocfr_state_e st;
        ocfr_field3_t retry;
        logic flag;
        logic alert;
        logic out_en;
        logic cc_lim;
        logic tstart;
    } ocfr_core_s;

    ocfr_if bus ();

    ocfr_core_s r;
    ocfr_core_s n;
    logic oc;
    logic below_floor;
    logic tmr_fire;
    ocfr_resp_t resp;
    ocfr_field3_t retry_cfg;

    ocfr_regs u_regs (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .bus(bus.regs),
        .cmd_code_i(cmd_code_i),
        .cmd_wr_i(cmd_wr_i),
        .cmd_rd_i(cmd_rd_i),
        .cmd_wdata_i(cmd_wdata_i),
        .cmd_rdata_o(cmd_rdata_o),
        .cmd_rvalid_o(cmd_rvalid_o)
    );

    ocfr_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .bus(bus.tmr)
    );

    // Timer and enable feed; the delay field sets both run-on time and restart spacing.
    assign bus.ce = ce_i;
    assign bus.tmr_start = r.tstart;
    assign bus.tmr_exp = ocfr_delay_field(bus.resp_cfg);
    assign bus.tmr_unit = time_unit_cycles_i;

    // Both sides are decoded from Linear format so differing exponents still compare correctly.
    assign oc = ocfr_lin_to_fix(iout_meas_i) > ocfr_lin_to_fix(bus.thresh);
    // The floor shares the output-voltage exponent, so the raw mantissas compare directly.
    assign below_floor = vout_meas_i < overcurrent_voltage_floor_i;
    assign resp = ocfr_resp_field(bus.resp_cfg);
    assign retry_cfg = ocfr_retry_field(bus.resp_cfg);
    // A done that lands while a fresh start is still in flight belongs to the old run.
    assign tmr_fire = bus.tmr_done && !r.tstart;

    // Next-state logic of the response machine.
    always_comb begin
        logic set_ev;
        logic shut_req;
        set_ev = 1'b0;
        shut_req = 1'b0;
        n = r;
        n.alert = 1'b0;
        n.tstart = 1'b0;
        unique case (r.st)
            OCFR_OFF: begin
                if (output_on_i) begin
                    n.st = OCFR_RUN;
                    n.retry = retry_cfg;
                end
            end
            OCFR_RUN: begin
                if (!output_on_i) begin
                    n.st = OCFR_OFF;
                end else if (oc) begin
                    set_ev = 1'b1;
                    n.alert = 1'b1;
                    if (resp == OCFR_RESP_RESUME) begin
                        n.st = OCFR_HOLD;
                    end else begin
                        n.st = OCFR_LIMIT;
                        n.tstart = (resp == OCFR_RESP_DELAY);
                    end
                end
            end
            OCFR_LIMIT: begin
                shut_req = ((resp == OCFR_RESP_FLOOR) && below_floor)
                    || ((resp == OCFR_RESP_DELAY) && tmr_fire);
                if (!output_on_i) begin
                    n.st = OCFR_OFF;
                end else if (!oc) begin
                    n.st = OCFR_RUN;
                    n.retry = retry_cfg;
                end else if (shut_req) begin
                    if (r.retry == OCFR_RETRY_NONE) begin
                        n.st = OCFR_LATCH;
                    end else begin
                        n.st = OCFR_SHUT;
                        n.tstart = 1'b1;
                    end
                end
            end
            OCFR_SHUT: begin
                if (!output_on_i) begin
                    n.st = OCFR_OFF;
                end else if (tmr_fire) begin
                    n.st = OCFR_RUN;
                    if (r.retry != OCFR_RETRY_FOREVER) begin
                        n.retry = 3'(r.retry - 3'h1);
                    end
                end
            end
            OCFR_LATCH: begin
                if (fault_clear_i) begin
                    n.st = OCFR_OFF;
                end
            end
            OCFR_HOLD: begin
                if (!output_on_i) begin
                    n.st = OCFR_OFF;
                end else if (!oc) begin
                    n.st = OCFR_RUN;
                end
            end
            default: begin
                n.st = OCFR_OFF;
            end
        endcase
        if (fault_clear_i) begin
            n.retry = retry_cfg;
        end
        // A new detection in the clearing cycle keeps the flag set.
        n.flag = set_ev || (r.flag && !fault_clear_i);
        n.out_en = (n.st == OCFR_RUN) || (n.st == OCFR_LIMIT);
        n.cc_lim = (n.st == OCFR_LIMIT);
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '{st: OCFR_OFF, default: '0};
        end else if (ce_i) begin
            r <= n;
        end
    end

    assign output_enable_o = r.out_en;
    assign current_limit_o = r.cc_lim;
    assign limit_level_o = bus.thresh;
    assign oc_fault_flag_o = r.flag;
    assign host_alert_o = r.alert;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // Checks on the response machine.
    oc_flag_set_a: assert property (ce_i && r.st == OCFR_RUN && output_on_i && oc |=> r.flag)
        else $error("over-current in run did not set the fault flag");
    alert_pulse_a: assert property (ce_i && r.st == OCFR_RUN && output_on_i && oc
        |=> host_alert_o ##1 (!host_alert_o || !ce_i))
        else $error("host notification missing or not a single pulse");
    brick_hold_a: assert property (ce_i && r.st == OCFR_LIMIT && output_on_i && oc
        && resp == OCFR_RESP_BRICK |=> current_limit_o && output_enable_o)
        else $error("brickwall mode left current limiting under fault");
    floor_keep_a: assert property (ce_i && r.st == OCFR_LIMIT && output_on_i && oc
        && resp == OCFR_RESP_FLOOR && !below_floor |=> current_limit_o)
        else $error("floor mode stopped limiting above the floor");
    floor_trip_a: assert property (ce_i && r.st == OCFR_LIMIT && output_on_i && oc
        && resp == OCFR_RESP_FLOOR && below_floor |=> !output_enable_o)
        else $error("floor mode kept output on below the floor");
    delay_expire_a: assert property (ce_i && r.st == OCFR_LIMIT && output_on_i && oc
        && resp == OCFR_RESP_DELAY && tmr_fire |=> !current_limit_o && !output_enable_o)
        else $error("delay mode kept limiting after the delay expired");
    resume_off_a: assert property (ce_i && r.st == OCFR_HOLD && output_on_i && oc
        |=> !output_enable_o)
        else $error("resume mode enabled output during fault");
    resume_on_a: assert property (ce_i && r.st == OCFR_HOLD && output_on_i && !oc
        |=> output_enable_o)
        else $error("resume mode did not re-enable output");
    latch_hold_a: assert property (r.st == OCFR_LATCH && !fault_clear_i
        |=> r.st == OCFR_LATCH && !output_enable_o)
        else $error("latched-off output left without a fault clear");
    retry_count_a: assert property (ce_i && r.st == OCFR_SHUT && output_on_i && tmr_fire
        && !fault_clear_i && r.retry != OCFR_RETRY_FOREVER |=> r.retry == $past(r.retry) - 3'h1)
        else $error("retry counter did not step down on a restart");
    retry_forever_a: assert property (ce_i && r.st == OCFR_SHUT && r.retry == OCFR_RETRY_FOREVER
        && !fault_clear_i |=> r.retry == OCFR_RETRY_FOREVER)
        else $error("continuous retry setting was consumed");
    no_retry_a: assert property (ce_i && r.st == OCFR_LIMIT && output_on_i && oc && r.retry
        == OCFR_RETRY_NONE && resp == OCFR_RESP_FLOOR && below_floor |=> r.st == OCFR_LATCH)
        else $error("zero retry setting did not latch off");

    // Main scenarios worth seeing.
    cov_brick_c: cover property (r.st == OCFR_LIMIT && resp == OCFR_RESP_BRICK);
    cov_retry_c: cover property (r.st == OCFR_SHUT ##[1:1000] r.st == OCFR_RUN);
    cov_latch_c: cover property (r.st == OCFR_LATCH ##[1:100] r.st == OCFR_OFF);
    cov_resume_c: cover property (r.st == OCFR_HOLD ##1 r.st == OCFR_RUN);

endmodule // ocfr_top
`default_nettype wire

// File: ocfr_host_model.sv
// Host controller model that drives the management register port of the fault block.
`default_nettype none
module ocfr_host_model (
    input wire logic clk_sys_i,
    output ocfr_pkg::ocfr_byte_t cmd_code_o,
    output logic cmd_wr_o,
    output logic cmd_rd_o,
    output ocfr_pkg::ocfr_word_t cmd_wdata_o,
    input wire ocfr_pkg::ocfr_word_t cmd_rdata_i,
    input wire logic cmd_rvalid_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import ocfr_pkg::*;

    // The port idles low; write data is inverted after use so stale data never looks valid.
    initial begin
        cmd_code_o = 8'h00;
        cmd_wr_o = 1'b0;
        cmd_rd_o = 1'b0;
        cmd_wdata_o = 16'h0000;
    end

    // One-cycle write strobe, launched on a falling edge and taken at the next rising edge.
    task automatic wr(input ocfr_byte_t code, input ocfr_word_t data);
        @(negedge clk_sys_i);
        cmd_code_o = code;
        cmd_wdata_o = data;
        cmd_wr_o = 1'b1;
        @(negedge clk_sys_i);
        cmd_wr_o = 1'b0;
        cmd_wdata_o = ~data;
    endtask

    // One-cycle read strobe; the answer is taken at the falling edge after the rising edge where it is flagged valid.
    task automatic rd(input ocfr_byte_t code, output ocfr_word_t data);
        int i;
        @(negedge clk_sys_i);
        cmd_code_o = code;
        cmd_rd_o = 1'b1;
        @(negedge clk_sys_i);
        cmd_rd_o = 1'b0;
        data = 16'hDEAD;
        for (i = 0; i < 4; i++) begin
            if (cmd_rvalid_i === 1'b1) begin
                data = cmd_rdata_i;
                break;
            end
            @(posedge clk_sys_i);
        end
    endtask
endmodule // ocfr_host_model
`default_nettype wire

// File: overcurrent_fault_response_bench.sv
// Self-checking testbench of the over-current fault response block.
`default_nettype none
module overcurrent_fault_response_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ocfr_pkg::*;

    localparam ocfr_word_t I_HIGH = 16'h00C8;
    localparam ocfr_word_t I_LOW = 16'h0032;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    ocfr_byte_t cmd_code;
    logic cmd_wr;
    logic cmd_rd;
    ocfr_word_t cmd_wdata;
    ocfr_word_t cmd_rdata;
    logic cmd_rvalid;
    ocfr_word_t iout = I_LOW;
    ocfr_word_t vout = 16'h01F4;
    ocfr_word_t floor_v = 16'h0064;
    ocfr_word_t unit_cyc = 16'h0002;
    logic output_on = 1'b0;
    logic fault_clear = 1'b0;
    logic oe;
    logic climit;
    ocfr_word_t level;
    logic flag;
    logic alert;
    int err_count = 0;
    int n_compared = 0;
    int alert_cnt = 0;

    // Half period of 20 ns gives the 25 MHz system clock.
    initial forever #20 clk_sys_i = ~clk_sys_i;

    // Alert pulses are counted at the falling edge, where the registered pulse has settled.
    always @(negedge clk_sys_i) if (alert === 1'b1) alert_cnt++;

    ocfr_host_model ocfr_host_model_i (.clk_sys_i(clk_sys_i), .cmd_code_o(cmd_code), .cmd_wr_o(cmd_wr),
        .cmd_rd_o(cmd_rd), .cmd_wdata_o(cmd_wdata), .cmd_rdata_i(cmd_rdata), .cmd_rvalid_i(cmd_rvalid));

    ocfr_top ocfr_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_code_i(cmd_code),
        .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_wdata_i(cmd_wdata), .cmd_rdata_o(cmd_rdata),
        .cmd_rvalid_o(cmd_rvalid), .iout_meas_i(iout), .vout_meas_i(vout),
        .overcurrent_voltage_floor_i(floor_v), .time_unit_cycles_i(unit_cyc), .output_on_i(output_on),
        .fault_clear_i(fault_clear), .output_enable_o(oe), .current_limit_o(climit),
        .limit_level_o(level), .oc_fault_flag_o(flag), .host_alert_o(alert));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Clears any latched fault, programs the response and then asks for the output.
    task automatic setup(input ocfr_byte_t cfg);
        output_on = 1'b0;
        iout = I_LOW;
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        ocfr_host_model_i.wr(OCFR_CMD_RESP, {8'h00, cfg});
        output_on = 1'b1;
        cyc(3);
        check("oe_setup", 16'(oe), 16'h0001);
        check("flag_cleared", 16'(flag), 16'h0000);
    endtask

    // Counts falling edges while a level keeps its value, with a bound so a stuck level cannot hang.
    task automatic span(ref logic sig, input logic lvl, output int n);
        n = 0;
        while (sig === lvl && n < 200) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic t_regs();
        ocfr_word_t d;
        ocfr_host_model_i.rd(OCFR_CMD_THRESH, d);
        check("thresh_rst", d, OCFR_THRESH_RST);
        ocfr_host_model_i.rd(OCFR_CMD_RESP, d);
        check("resp_rst", d, 16'h0000);
        ocfr_host_model_i.wr(OCFR_CMD_THRESH, 16'h0064);
        cyc(1);
        check("limit_level", level, 16'h0064);
        ocfr_host_model_i.wr(8'h99, 16'hFFFF);
        ocfr_host_model_i.rd(OCFR_CMD_THRESH, d);
        check("thresh_rd", d, 16'h0064);
        ocfr_host_model_i.rd(8'h99, d);
        check("unmapped_rd", d, 16'h0000);
        ocfr_host_model_i.wr(OCFR_CMD_RESP, 16'hABCD);
        ocfr_host_model_i.rd(OCFR_CMD_RESP, d);
        check("resp_rd", d, 16'h00CD);
        $display("test regs done");
    endtask

    task automatic t_brick();
        int a0;
        setup(8'h00);
        a0 = alert_cnt;
        vout = 16'h0000;
        iout = I_HIGH;
        cyc(3);
        check("brick_limit", 16'(climit), 16'h0001);
        check("brick_flag", 16'(flag), 16'h0001);
        cyc(40);
        check("brick_still", 16'({oe, climit}), 16'h0003);
        check("brick_alerts", 16'(alert_cnt - a0), 16'h0001);
        iout = I_LOW;
        vout = 16'h01F4;
        cyc(3);
        check("brick_release", 16'({climit, flag}), 16'h0001);
        $display("test brick done");
    endtask

    task automatic t_floor();
        setup(8'h41);
        iout = I_HIGH;
        cyc(20);
        check("floor_limit", 16'({oe, climit}), 16'h0003);
        vout = 16'h0032;
        cyc(3);
        check("floor_shut", 16'(oe), 16'h0000);
        iout = I_LOW;
        vout = 16'h01F4;
        cyc(30);
        check("latched_off", 16'(oe), 16'h0000);
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(4);
        check("clear_restart", 16'(oe), 16'h0001);
        $display("test floor done");
    endtask

    task automatic t_delay();
        int n;
        setup(8'h89);
        iout = I_HIGH;
        cyc(1);
        span(climit, 1'b1, n);
        check("run_on_len", 16'(n), 16'h0006);
        check("shut_after", 16'(oe), 16'h0000);
        span(oe, 1'b0, n);
        check("retry_gap", 16'(n >= 4 && n <= 8), 16'h0001);
        cyc(1);
        span(climit, 1'b1, n);
        check("run_on_again", 16'(n), 16'h0006);
        cyc(40);
        check("retries_used", 16'(oe), 16'h0000);
        $display("test delay done");
    endtask

    task automatic t_forever();
        int rises;
        logic prev;
        setup(8'hB8);
        iout = I_HIGH;
        rises = 0;
        prev = oe;
        repeat (200) begin
            cyc(1);
            if (oe === 1'b1 && prev === 1'b0) rises++;
            prev = oe;
        end
        check("endless_retry", 16'(rises >= 5), 16'h0001);
        $display("test forever done");
    endtask

    task automatic t_resume();
        int a0;
        setup(8'hC0);
        a0 = alert_cnt;
        iout = I_HIGH;
        cyc(3);
        check("resume_off", 16'(oe), 16'h0000);
        check("resume_flag", 16'(flag), 16'h0001);
        cyc(20);
        check("resume_hold", 16'(oe), 16'h0000);
        ce_i = 1'b0;
        iout = I_LOW;
        cyc(5);
        check("frozen_hold", 16'(oe), 16'h0000);
        ce_i = 1'b1;
        cyc(3);
        check("resume_on", 16'({oe, climit}), 16'h0002);
        check("resume_alert", 16'(alert_cnt - a0), 16'h0001);
        $display("test resume done");
    endtask

    // Watchdog sized well beyond the few hundred cycles the tests take.
    initial begin
        #800000;
        err_count++;
        $display("[ERR] watchdog expected finish seen hang");
        stop_test();
    end

    initial begin
        cyc(2);
        rst_i = 1'b0;
        check("rst_level", level, OCFR_THRESH_RST);
        check("rst_outputs", 16'({oe, climit, flag}), 16'h0000);
        t_regs();
        t_brick();
        t_floor();
        t_delay();
        t_forever();
        t_resume();
        rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        check("rst2_level", level, OCFR_THRESH_RST);
        check("rst2_outputs", 16'({oe, climit, flag}), 16'h0000);
        $display("test reset done");
        stop_test();
    end
endmodule // overcurrent_fault_response_bench
`default_nettype wire
